// [dv/printer_model.sv]
// printer model: takes bytes on the strobe, answers with busy and ack
// assumes one clock; delay sets ack lateness in cycles
`timescale 1ns/100ps
module printer_model (
  // host side
  input wire logic pclk,
  input wire logic data_strobe_n,
  input wire logic [7:0] print_data,
  // scenario control
  input wire logic [7:0] delay,
  input wire logic online,
  input wire logic out_of_paper,
  // printer lines
  output logic busy,
  output logic byte_accepted_pulse_n,
  output logic select,
  output logic paper_out,
  output logic fault_n,
  output logic supply_present,
  // observation
  output logic [7:0] last_byte,
  output int n_bytes
);
  logic taking = 1'b0;
  assign busy = taking || !online || out_of_paper;
  assign select = online;
  assign paper_out = out_of_paper;
  assign fault_n = online && !out_of_paper;
  assign supply_present = 1'b1;
  initial begin
    byte_accepted_pulse_n = 1'b1;
    n_bytes = 0;
    forever begin
      @(posedge pclk);
      if (!data_strobe_n) begin
        last_byte <= print_data;
        taking <= 1'b1;
        while (!data_strobe_n) @(posedge pclk);
        repeat (delay) @(posedge pclk);
        byte_accepted_pulse_n <= 1'b0;
        repeat (4) @(posedge pclk);
        byte_accepted_pulse_n <= 1'b1;
        taking <= 1'b0;
        n_bytes <= n_bytes + 1;
      end
    end
  end
endmodule

// [dv/prn_port_chk.sv]
// checker for the printer port pins
// assumes a bind onto parallel_printer_port
`timescale 1ns/100ps
module prn_port_chk
  import prn_port_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  // printer
  input wire logic [7:0] print_data,
  input wire logic data_strobe_n,
  input wire logic init_n,
  input wire logic receive_machine_line,
  input wire logic byte_accepted_pulse_n,
  input wire logic select,
  input wire logic paper_out,
  input wire logic fault_n,
  input wire logic supply_present,
  input wire logic adapter_style_interface
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic ack_ok;
  wire st_rd = psel && penable && !pwrite && paddr == {2'b00, IDX_STATUS, 2'b00};
  // ack seen since the last strobe
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) ack_ok <= 1'b1;
    else if ($fell(byte_accepted_pulse_n)) ack_ok <= 1'b1;
    else if ($fell(data_strobe_n)) ack_ok <= 1'b0;
  strobe_width_a: assert property (
    $fell(data_strobe_n) |-> ##199 !data_strobe_n ##1 data_strobe_n) else $error("strobe width");
  data_hold_a: assert property (
    !data_strobe_n |-> $stable(print_data)) else $error("data moved in strobe");
  data_setup_a: assert property (
    $fell(data_strobe_n) |-> print_data == $past(print_data, 100)) else $error("data setup");
  ack_gate_a: assert property (
    $fell(data_strobe_n) |-> ack_ok) else $error("strobe without ack");
  strobe_gap_a: assert property (
    $rose(data_strobe_n) |-> data_strobe_n [*8]) else $error("strobe gap");
  rml_variant_a: assert property (
    !adapter_style_interface |-> !receive_machine_line) else $error("rml driven");
  status_read_a: assert property (st_rd |-> prdata[0] == paper_out &&
    prdata[3] == select && prdata[4] == !fault_n && prdata[7] == supply_present)
    else $error("status bits");
  reset_idle_a: assert property (disable iff (1'b0)
    !presetn |-> data_strobe_n && init_n) else $error("reset levels");
  cover property ($fell(data_strobe_n));
  cover property (st_rd);
  cover property (receive_machine_line);
endmodule

// [dv/tb_parallel_printer_port.sv]
// bench for the printer port: apb master, printer model, checker bind
// assumes the design answers apb with pready
`timescale 1ns/100ps
module tb_parallel_printer_port;
  import prn_port_pkg::*;
  logic pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic online = 1, pout = 0, adapter_style_interface = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, data_strobe_n, init_n, receive_machine_line, busy, irq;
  logic byte_accepted_pulse_n, select, paper_out, fault_n, supply_present;
  logic [7:0] print_data, port_a, last_byte, dly = 8'h04;
  logic [3:0] port_c_hi;
  int n_fail = 0, n_checks = 0, n_bytes, cyc = 0;
  always #2.5 pclk = ~pclk;
  parallel_printer_port i_parallel_printer_port (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .print_data, .data_strobe_n, .init_n,
    .receive_machine_line, .port_a, .port_c_hi, .busy, .byte_accepted_pulse_n, .select,
    .paper_out, .fault_n, .supply_present, .adapter_style_interface, .irq);
  printer_model i_printer_model (.pclk, .data_strobe_n, .print_data, .delay(dly), .online,
    .out_of_paper(pout), .busy, .byte_accepted_pulse_n, .select, .paper_out, .fault_n,
    .supply_present, .last_byte, .n_bytes);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task wait_bytes(input int n);
    for (int k = 0; k < 2000 && n_bytes < n; k++) @(posedge pclk);
    @(negedge pclk);
    chk(n_bytes, n);
  endtask
  task end_of_test;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task t_ports;
    chk(data_strobe_n, 1);
    apb(1, IDX_PORT_A, 32'hA5);
    apb(1, IDX_PORT_C_HI, 32'h9);
    chk({port_a, port_c_hi}, 12'hA59);
    apb(0, 8'hFF, 0);
    chk(err, 1);
  endtask
  task t_status;
    apb(1, IDX_IRQ_MASK, 32'h2);
    for (int i = 0; i < 4; i++) begin
      @(posedge pclk);
      {online, pout} <= 2'(i);
      apb(0, IDX_STATUS, 0);
      chk({rd[7], rd[4:3], rd[0]}, {1'b1, !(online && !pout), online, pout});
    end
    chk(irq, 1);
    apb(1, IDX_IRQ_MASK, 0);
    chk(irq, 0);
    apb(1, IDX_IRQ_MASK, 32'h2);
    chk(irq, 1);
    @(posedge pclk);
    {online, pout} <= 2'b10;
    apb(1, IDX_IRQ_STAT, 32'h2);
    chk(irq, 0);
  endtask
  task t_print;
    apb(1, IDX_SIGNAL, 32'h94);
    apb(1, IDX_SIGNAL, 32'h05);
    apb(0, IDX_SIGNAL, 0);
    chk(rd[3:0], 4'hB);
    apb(1, IDX_IRQ_MASK, 32'h1);
    chk(irq, 0);
    apb(1, IDX_DATA, 32'h3C);
    apb(1, IDX_DATA, 32'h55);
    wait_bytes(1);
    chk({print_data, last_byte}, 16'h3C3C);
    chk(irq, 1);
    apb(1, IDX_IRQ_STAT, 32'h1);
    chk(irq, 0);
    dly <= 8'd60;
    apb(1, IDX_DATA, 32'hC3);
    wait_bytes(2);
    chk(last_byte, 8'hC3);
    @(posedge pclk);
    online <= 1'b0;
    apb(1, IDX_DATA, 32'h11);
    repeat (400) @(posedge pclk);
    chk(n_bytes, 2);
    online <= 1'b1;
    wait_bytes(3);
    chk(last_byte, 8'h11);
  endtask
  task t_lines;
    @(posedge pclk);
    adapter_style_interface <= 1'b1;
    apb(1, IDX_SIGNAL, 32'h07);
    chk(receive_machine_line, 1);
    @(posedge pclk);
    adapter_style_interface <= 1'b0;
    @(negedge pclk);
    chk(receive_machine_line, 0);
    apb(1, IDX_SIGNAL, 32'h0E);
    chk(init_n, 0);
    apb(1, IDX_SIGNAL, 32'h0F);
    chk(init_n, 1);
    apb(1, IDX_PRIME_MASK, 32'h00);
    chk(init_n, 0);
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test;
    end
  end
  initial begin
    // falling edge at time zero resets the design before its first clock
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_ports;
    t_status;
    t_print;
    t_lines;
    end_of_test;
  end
endmodule
bind parallel_printer_port prn_port_chk i_prn_port_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .prdata, .print_data, .data_strobe_n, .init_n, .receive_machine_line,
  .byte_accepted_pulse_n, .select, .paper_out, .fault_n, .supply_present,
  .adapter_style_interface);

// [rtl/parallel_printer_port.sv]
// parallel printer port: APB registers, control lines, strobed byte output
// assumes printer lines synchronous to pclk; one APB master
//
// Summary of operation
// (RL1) Port A and upper port C act as plain static outputs for control levels.
// (RL2) Port B with lower port C runs a strobed handshake transfer.
// (RL3) Each byte is shown on all eight data lines; other levels come from ports A and C.
// (RL4) The strobe idles high and pulses low to deliver a byte.
// (RL5) The printer holds busy high whenever it cannot take data.
// (RL6) The printer drives select high when selected.
// (RL7) The printer pulses acknowledge low when the byte is taken.
// (RL8) The receive machine line is driven only in adapter style.
// (RL9) A static setting picks adapter style or the alternative interface.
// (RL10) The initialize output is low to reset the printer, high otherwise.
// (RL11) The printer drives paper out high when out of paper.
// (RL12) Reading the status register returns the live printer status lines.
// (RL13) Writing the data register loads the byte to print.
// (RL14) Data settle before strobe; a transfer starts only with busy low and ack seen.
`timescale 1ns/100ps
module parallel_printer_port
  import prn_port_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // printer
  output logic [7:0] print_data,
  output logic data_strobe_n,
  output logic init_n,
  output logic receive_machine_line,
  output logic [7:0] port_a,
  output logic [3:0] port_c_hi,
  input wire logic busy,
  input wire logic byte_accepted_pulse_n,
  input wire logic select,
  input wire logic paper_out,
  input wire logic fault_n,
  input wire logic supply_present,
  // static strap: high selects adapter style
  input wire logic adapter_style_interface,
  // interrupt
  output logic irq
);
  // registers sit one per aligned word: byte address is four times the index
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == {2'b00, idx, 2'b00});
  endfunction

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // writes take effect in the access cycle
  wire wr = psel & penable & pwrite;
  wire rd_en = psel & ~pwrite;
  wire h_stat = hit(paddr, IDX_STATUS);
  wire h_data = hit(paddr, IDX_DATA);
  wire h_sig = hit(paddr, IDX_SIGNAL);
  wire h_pm = hit(paddr, IDX_PRIME_MASK);
  wire h_cfg = hit(paddr, IDX_CONFIG);
  wire h_ist = hit(paddr, IDX_IRQ_STAT);
  wire h_imk = hit(paddr, IDX_IRQ_MASK);
  wire h_pa = hit(paddr, IDX_PORT_A);
  wire h_pc = hit(paddr, IDX_PORT_C_HI);
  wire h_xf = hit(paddr, IDX_XFER);
  wire mapped = h_stat | h_data | h_sig | h_pm | h_cfg | h_ist | h_imk | h_pa | h_pc | h_xf;
  // every register answers at once, so no wait state is ever inserted
  assign pready = 1'b1;
  // unmapped offsets error out instead of aliasing onto a real register
  assign pslverr = psel & penable & ~mapped;

  logic inte, recv_flag, mask_flag, prime, mode_set, pending;
  logic [IRQ_W-1:0] irq_stat, irq_mask;
  logic [7:0] data_reg;
  logic [CNT_W-1:0] cnt;
  xfer_e state;
  logic ack_seen;

  // ready only once the held byte has gone and the printer is free
  wire ready_bit = ~pending & ~busy;
  wire [7:0] status_word = {supply_present, 2'b00, ~fault_n, select, 1'b0,
                            ready_bit, paper_out}; // RL12
  // command code sits above the flag value bit
  wire [2:0] sig_code = pwdata[SIG_CODE_MSB:SIG_CODE_LSB];
  wire sig_val = pwdata[SIG_VALUE_BIT];
  wire sig_cmd = wr & h_sig & ~pwdata[SIG_MODE_BIT];

  // ----------------------------------------------------------------
  // printer events
  // ----------------------------------------------------------------
  // detectors reset high: no false ack or fault edge at release of reset
  logic ack_fall, paper_rise, fault_fall;
  prn_edge_sync u_ack (.pclk(pclk), .presetn(presetn), .line_in(byte_accepted_pulse_n),
    .fall(ack_fall), .rise());
  prn_edge_sync u_flt (.pclk(pclk), .presetn(presetn), .line_in(fault_n),
    .fall(fault_fall), .rise());
  prn_edge_sync u_paper (.pclk(pclk), .presetn(presetn), .line_in(paper_out),
    .fall(), .rise(paper_rise));
  // an ack counts as an event only while the interrupt enable flag is on
  wire ack_event = ack_fall & inte;
  wire [IRQ_W-1:0] ev = {fault_fall, paper_rise, ack_event};
  wire [IRQ_W-1:0] ist_clr = (wr & h_ist) ? pwdata[IRQ_W-1:0] : '0;
  assign irq = |(irq_stat & irq_mask);

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inte <= 1'b0;
      recv_flag <= 1'b0;
      mask_flag <= 1'b1;
      // prime starts released so the printer is not held in reset
      prime <= 1'b0;
      mode_set <= 1'b0;
      irq_stat <= '0;
      irq_mask <= '0;
      port_a <= 8'h00;
      port_c_hi <= 4'h0;
    end else begin
      // set wins over a clear of the same bit in one cycle
      irq_stat <= (irq_stat & ~ist_clr) | ev;
      if (wr & h_imk) irq_mask <= pwdata[IRQ_W-1:0];
      if (wr & h_pa) port_a <= pwdata[7:0]; // RL1
      if (wr & h_pc) port_c_hi <= pwdata[3:0]; // RL1
      if (wr & h_sig & pwdata[SIG_MODE_BIT]) mode_set <= 1'b1; // RL2
      if (sig_cmd && sig_code == SIG_INTE) inte <= sig_val;
      if (sig_cmd && sig_code == SIG_RECV) recv_flag <= sig_val;
      if (sig_cmd && sig_code == SIG_MASK) mask_flag <= ~sig_val;
      if (sig_cmd && sig_code == SIG_PRIME) prime <= ~sig_val; // RL10
      if (wr & h_pm) begin
        prime <= ~pwdata[PM_PRIME_BIT]; // RL10
        mask_flag <= ~pwdata[PM_MASK_BIT];
      end
    end
  end

  // RL9 RL8
  // the flag is kept in either variant; only the pin is gated by the strap
  assign receive_machine_line = adapter_style_interface & recv_flag;
  assign init_n = ~prime; // RL10

  // ----------------------------------------------------------------
  // strobed transfer
  // ----------------------------------------------------------------
  wire load = wr & h_data & ~pending; // RL13
  // a write while a byte is pending is dropped; software polls ready first
  // busy high or an ack still owed from the last byte holds the next one back
  wire can_start = pending & mode_set & ~busy & ack_seen; // RL14 RL5
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= XF_IDLE;
      data_reg <= 8'h00;
      pending <= 1'b0;
      cnt <= '0;
      // the first byte after reset owes no ack
      ack_seen <= 1'b1;
      data_strobe_n <= 1'b1;
      print_data <= 8'h00;
    end else begin
      if (load) begin
        data_reg <= pwdata[7:0]; // RL13
        pending <= 1'b1;
      end
      if (ack_fall) ack_seen <= 1'b1; // RL7
      unique case (state)
        XF_IDLE: begin
          if (can_start) begin
            print_data <= data_reg; // RL3
            cnt <= CNT_W'(SETUP_CYC - 1);
            state <= XF_SETUP;
          end
        end
        XF_SETUP: begin
          // data already on the lines; wait out the setup time first
          if (cnt == '0) begin
            data_strobe_n <= 1'b0; // RL4
            cnt <= CNT_W'(STROBE_CYC - 1);
            state <= XF_STROBE;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        XF_STROBE: begin
          if (cnt == '0) begin
            data_strobe_n <= 1'b1; // RL4
            // an ack on this very edge still counts for the next byte
            ack_seen <= ack_fall;
            pending <= 1'b0;
            state <= XF_WAIT;
          end else begin
            cnt <= cnt - 1'b1;
          end
        end
        // one spare cycle lets busy from the printer settle before idle
        XF_WAIT: state <= XF_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // unmapped reads return zero alongside the error response
  wire [31:0] rd_mux =
    h_stat ? {24'h000000, status_word} :
    h_data ? {24'h000000, data_reg} :
    h_sig ? {28'h0000000, mask_flag, recv_flag, inte, mode_set} :
    h_cfg ? {31'h00000000, adapter_style_interface} :
    h_ist ? {29'h00000000, irq_stat} :
    h_imk ? {29'h00000000, irq_mask} :
    h_pa ? {24'h000000, port_a} :
    h_pc ? {28'h0000000, port_c_hi} :
    h_xf ? {27'h0000000, ack_seen, pending, state == XF_IDLE, ~data_strobe_n, init_n} :
    32'h00000000;
  assign prdata = rd_en ? rd_mux : 32'h00000000;
endmodule

// [rtl/prn_edge_sync.sv]
// edge detector for printer handshake inputs
// assumes inputs already synchronous to pclk
`timescale 1ns/100ps
module prn_edge_sync (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // line
  input wire logic line_in,
  output logic fall,
  output logic rise
);
  logic last;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last <= 1'b1;
    end else begin
      last <= line_in;
    end
  end
  assign fall = last & ~line_in;
  assign rise = ~last & line_in;
endmodule

// [rtl/prn_port_pkg.sv]
// constants for the parallel printer port: register map, fields, timing
// assumes an APB slave with 32-bit data, one register per aligned word
package prn_port_pkg;
  // register indices: not every offset is a multiple of four, so the byte
  // address on the bus is four times the index
  localparam logic [7:0] IDX_STATUS = 8'h68;
  localparam logic [7:0] IDX_DATA = 8'h6A;
  localparam logic [7:0] IDX_SIGNAL = 8'h6E;
  localparam logic [7:0] IDX_PRIME_MASK = 8'h6C;
  localparam logic [7:0] IDX_CONFIG = 8'h70;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h71;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h72;
  localparam logic [7:0] IDX_PORT_A = 8'h73;
  localparam logic [7:0] IDX_PORT_C_HI = 8'h74;
  localparam logic [7:0] IDX_XFER = 8'h75;
  localparam int ADDR_W = 12;
  // status word bit positions
  localparam int ST_PAPER_OUT = 0;
  localparam int ST_RDRQ = 1;
  localparam int ST_SELECT = 3;
  localparam int ST_FAULT = 4;
  localparam int ST_SUPPLY = 7;
  // signal command word: bits 3:1 select the flag, bit 0 its value
  localparam int SIG_CODE_MSB = 3;
  localparam int SIG_CODE_LSB = 1;
  localparam int SIG_VALUE_BIT = 0;
  localparam logic [2:0] SIG_INTE = 3'h2;
  localparam logic [2:0] SIG_RECV = 3'h3;
  localparam logic [2:0] SIG_MASK = 3'h4;
  localparam logic [2:0] SIG_PRIME = 3'h7;
  localparam int SIG_MODE_BIT = 7;
  localparam int PM_PRIME_BIT = 7;
  localparam int PM_MASK_BIT = 4;
  // interrupt status bits
  localparam int IRQ_ACK = 0;
  localparam int IRQ_PAPER = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_W = 3;
  // timing
  localparam int CLK_NS = 5;
  localparam int SETUP_NS = 500;
  localparam int STROBE_NS = 1000;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W = 8;
  typedef enum logic [1:0] {XF_IDLE, XF_SETUP, XF_STROBE, XF_WAIT} xfer_e;
endpackage
